// >>> include/adcpd_pkg.sv
// package: constants and types for the adc power-down controller
package adcpd_pkg;
    localparam int ADCPD_CFG_W = 12;
    localparam logic [15:0] ADCPD_SW_PD_WORD = 16'h8000;
    localparam int ADCPD_WORD_W = 16;
    localparam int ADCPD_RES_W = 10;
    localparam logic [ADCPD_RES_W-1:0] ADCPD_RES_ONES = 10'h3ff;
    localparam logic [ADCPD_RES_W-1:0] ADCPD_RES_ZEROS = 10'h000;
    localparam int ADCPD_CLK_MHZ = 125;
    localparam int ADCPD_WARMUP_MS = 20;
    localparam int ADCPD_WARMUP_CYC = ADCPD_WARMUP_MS * 1000 * ADCPD_CLK_MHZ;
    localparam int ADCPD_CONV_CYC = 14;
    localparam logic [ADCPD_CFG_W-1:0] ADCPD_CFG_RST = 12'h000;

    typedef enum logic [2:0] {
        ADCPD_ACTIVE,
        ADCPD_AUTO_PD,
        ADCPD_SW_PD,
        ADCPD_HW_PD,
        ADCPD_WARMUP
    } adcpd_state_t;

    // status bundle toward the analog core
    typedef struct packed {
        logic core_on;
        logic ref_on;
        logic ready;
        logic sweep_restart;
        logic fifo_flush;
    } adcpd_power_t;

    // one framed serial word from the link side
    typedef struct packed {
        logic is_cfg_write;
        logic [ADCPD_WORD_W-1:0] word;
    } adcpd_word_t;
endpackage : adcpd_pkg

// >>> design/adcpd_top.sv
// power-state controller of a serial adc: auto, software and pin power-down
// How it works
// - enter low-power when conversion finishes
// - reference stays on in auto power-down
// - select, sync or start wakes within four sys_clk cycles
// - word 8000h enters full software power-down from active or auto power-down
// - power-down pin stops everything immediately
// - activity wakes from software power-down
// - pin release, warm-up 20 ms internal reference
// - configuration kept through every power-down
// - sweep restarts at first step after power-down
// - every power-down empties the result fifo
// - out-of-range input clamps to ones or zeros
// - twelve-bit config write starts no conversion
`timescale 1ns/1ps
module adcpd_top #(
    parameter int WARMUP_CYC = adcpd_pkg::ADCPD_WARMUP_CYC
) (
    // system
    input wire logic sys_clk,
    input wire logic resetn,
    // link side, serial clock domain
    input wire logic sclk,
    input wire logic sdi,
    input wire logic frame_sync_in,
    // host pins, async
    input wire logic cs_n,
    input wire logic conversion_start_in,
    input wire logic powerdown_pin_n,
    // analog front end
    input wire logic internal_ref_sel,
    input wire logic conv_request,
    input wire logic above_ref_high,
    input wire logic below_ref_low,
    input wire logic [adcpd_pkg::ADCPD_RES_W-1:0] raw_code,
    // outputs
    output adcpd_pkg::adcpd_power_t power_q,
    output logic [adcpd_pkg::ADCPD_CFG_W-1:0] config_register,
    output logic [adcpd_pkg::ADCPD_RES_W-1:0] result_q,
    output logic result_valid_q,
    output logic conv_busy_q
);
    import adcpd_pkg::*;

    initial begin
        if (WARMUP_CYC < 1) begin
            $error("WARMUP_CYC must be at least one");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link domain: shift 16 bits per frame, toggle on each word
    logic [ADCPD_WORD_W-1:0] sh_q;
    logic [3:0] bit_cnt_q;
    logic [ADCPD_WORD_W-1:0] word_hold_q;
    logic word_tgl_q;
    logic fs_q;
    logic [2:0] lrst_q;

    // reset into link domain; sclk may stop; it resets the bit counter, shift, hold and toggle registers
    always_ff @(posedge sclk) begin
        lrst_q <= {lrst_q[1:0], resetn};
    end

    always_ff @(negedge sclk) begin
        fs_q <= frame_sync_in;
    end

    always_ff @(posedge sclk) begin
        if (!lrst_q[2] || cs_n || fs_q) begin
            bit_cnt_q <= 4'h0;
            sh_q <= 16'h0000;
        end else begin
            sh_q <= {sh_q[ADCPD_WORD_W-2:0], sdi};
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge sclk) begin
        if (!lrst_q[2]) begin
            word_tgl_q <= 1'b0;
            word_hold_q <= 16'h0000;
        end else if (!cs_n && !fs_q && bit_cnt_q == 4'hf) begin
            word_hold_q <= {sh_q[ADCPD_WORD_W-2:0], sdi};
            word_tgl_q <= ~word_tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // crossings into sys_clk
    logic [2:0] tgl_s_q;
    logic [1:0] cs_s_q, fs_s_q, cst_s_q, pd_s_q;
    logic [ADCPD_WORD_W-1:0] word_s_q;
    logic word_ev;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tgl_s_q <= 3'h0;
            cs_s_q <= 2'h3;
            fs_s_q <= 2'h0;
            cst_s_q <= 2'h3;
            pd_s_q <= 2'h3;
        end else begin
            tgl_s_q <= {tgl_s_q[1:0], word_tgl_q};
            cs_s_q <= {cs_s_q[0], cs_n};
            fs_s_q <= {fs_s_q[0], frame_sync_in};
            cst_s_q <= {cst_s_q[0], conversion_start_in};
            pd_s_q <= {pd_s_q[0], powerdown_pin_n};
        end
    end

    assign word_ev = tgl_s_q[2] ^ tgl_s_q[1];

    // word is stable for the whole toggle settle time
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            word_s_q <= 16'h0000;
        end else if (word_ev) begin
            word_s_q <= word_hold_q;
        end
    end

    logic wake_ev, pd_pin_act, sw_pd_ev, cfg_ev;
    logic word_ev_q;
    logic act_lvl, act_q;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            word_ev_q <= 1'b0;
        end else begin
            word_ev_q <= word_ev;
        end
    end

    // reset value matches idle pins, so no false wake after reset
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            act_q <= 1'b0;
        end else begin
            act_q <= act_lvl;
        end
    end

    // a level would undo software power-down while the command frame
    // still holds select low, so only a fresh edge of activity wakes
    assign act_lvl = !cs_s_q[1] || fs_s_q[1] || !cst_s_q[1];
    assign wake_ev = act_lvl && !act_q;
    // raw pin too, so power-down acts at the next sys_clk edge, ahead of the synchronizer
    assign pd_pin_act = !pd_s_q[1] || !powerdown_pin_n;
    assign sw_pd_ev = word_ev_q && word_s_q == ADCPD_SW_PD_WORD;
    // top nibble 0xa marks a config write in this map
    assign cfg_ev = word_ev_q && word_s_q[15:12] == 4'ha;

    ////////////////////////////////////////////////////////////////////
    // power state machine
    adcpd_state_t state_q;
    logic [31:0] warm_cnt_q;
    logic [3:0] conv_cnt_q;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q <= ADCPD_AUTO_PD;
            warm_cnt_q <= 32'h0;
        end else if (pd_pin_act) begin
            state_q <= ADCPD_HW_PD;
            warm_cnt_q <= 32'h0;
        end else begin
            case (state_q)
            ADCPD_ACTIVE: begin
                if (sw_pd_ev) begin
                    state_q <= ADCPD_SW_PD;
                end else if (conv_busy_q && conv_cnt_q == 4'h1) begin
                    state_q <= ADCPD_AUTO_PD;
                end
            end
            ADCPD_AUTO_PD: begin
                if (sw_pd_ev) begin
                    state_q <= ADCPD_SW_PD;
                end else if (wake_ev) begin
                    state_q <= ADCPD_ACTIVE;
                end
            end
            ADCPD_SW_PD: begin
                if (wake_ev) begin
                    // external ref: no delay
                    state_q <= internal_ref_sel ? ADCPD_WARMUP : ADCPD_ACTIVE;
                    warm_cnt_q <= 32'h0;
                end
            end
            ADCPD_HW_PD: begin
                // pin released
                state_q <= internal_ref_sel ? ADCPD_WARMUP : ADCPD_ACTIVE;
                warm_cnt_q <= 32'h0;
            end
            ADCPD_WARMUP: begin
                if (warm_cnt_q == 32'(WARMUP_CYC - 1)) begin
                    state_q <= ADCPD_ACTIVE;
                end else begin
                    warm_cnt_q <= warm_cnt_q + 32'h1;
                end
            end
            default: begin
                state_q <= ADCPD_AUTO_PD;
            end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion timing; config writes never start one
    always_ff @(posedge sys_clk) begin
        if (!resetn || pd_pin_act) begin
            conv_busy_q <= 1'b0;
            conv_cnt_q <= 4'h0;
        end else if (conv_busy_q) begin
            conv_cnt_q <= conv_cnt_q - 4'h1;
            if (conv_cnt_q == 4'h1) begin
                conv_busy_q <= 1'b0;
            end
        end else if (state_q == ADCPD_ACTIVE && conv_request && !cfg_ev) begin
            conv_busy_q <= 1'b1;
            conv_cnt_q <= 4'(ADCPD_CONV_CYC);
        end
    end

    // out-of-range clamp
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            result_q <= ADCPD_RES_ZEROS;
            result_valid_q <= 1'b0;
        end else begin
            result_valid_q <= conv_busy_q && conv_cnt_q == 4'h1;
            if (conv_busy_q && conv_cnt_q == 4'h1) begin
                if (above_ref_high) begin
                    result_q <= ADCPD_RES_ONES;
                end else if (below_ref_low) begin
                    result_q <= ADCPD_RES_ZEROS;
                end else begin
                    result_q <= raw_code;
                end
            end
        end
    end

    // only reset or a config write touch it, never power-down
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            config_register <= ADCPD_CFG_RST;
        end else if (cfg_ev && !pd_pin_act) begin
            config_register <= word_s_q[ADCPD_CFG_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power outputs
    logic entering_pd;
    assign entering_pd = pd_pin_act || sw_pd_ev ||
        (state_q == ADCPD_ACTIVE && conv_busy_q && conv_cnt_q == 4'h1);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            power_q <= '0;
        end else begin
            // pin gates the core at once, not one state later
            power_q.core_on <= !pd_pin_act && (state_q == ADCPD_ACTIVE ||
                state_q == ADCPD_WARMUP);
            // ref off only in full power-down
            power_q.ref_on <= !(state_q == ADCPD_SW_PD ||
                state_q == ADCPD_HW_PD || pd_pin_act);
            power_q.ready <= !pd_pin_act && state_q == ADCPD_ACTIVE;
            power_q.sweep_restart <= entering_pd;
            power_q.fifo_flush <= entering_pd;
        end
    end
endmodule : adcpd_top

// >>> testbench/adcpd_monitor.sv
// checker: port assertions of the adc power-down controller
`timescale 1ns/1ps
module adcpd_monitor
    import adcpd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // pins
    input wire logic cs_n,
    input wire logic powerdown_pin_n,
    input wire logic above_ref_high,
    input wire logic below_ref_low,
    // outputs
    input wire adcpd_power_t power_q,
    input wire logic [ADCPD_CFG_W-1:0] config_register,
    input wire logic [ADCPD_RES_W-1:0] result_q,
    input wire logic result_valid_q,
    input wire logic conv_busy_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_pin_off;
        !powerdown_pin_n |=> !power_q.ref_on && !power_q.core_on
            && !power_q.ready;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pin power-down left power on");
    property p_flush;
        !powerdown_pin_n ##1 !powerdown_pin_n |=> power_q.fifo_flush;
    endproperty
    a_flush: assert property (p_flush)
        else $error("fifo not flushed while pin held");
    property p_sweep;
        $rose(power_q.fifo_flush) |-> power_q.sweep_restart;
    endproperty
    a_sweep: assert property (p_sweep)
        else $error("sweep restart missing at power-down");
    property p_cfg_keep;
        power_q.fifo_flush |-> $stable(config_register);
    endproperty
    a_cfg_keep: assert property (p_cfg_keep)
        else $error("config changed at power-down");
    property p_conv_len;
        $rose(conv_busy_q) |-> conv_busy_q[*8] ##1 conv_busy_q[*6]
            ##1 !conv_busy_q;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");
    property p_auto_pd;
        $fell(conv_busy_q) && powerdown_pin_n |-> ##[0:2]
            (!power_q.ready && power_q.ref_on);
    endproperty
    a_auto_pd: assert property (p_auto_pd)
        else $error("no auto power-down after conversion");
    property p_clamp_hi;
        result_valid_q && above_ref_high |-> result_q == ADCPD_RES_ONES;
    endproperty
    a_clamp_hi: assert property (p_clamp_hi)
        else $error("high clamp wrong");
    property p_clamp_lo;
        result_valid_q && below_ref_low && !above_ref_high
            |-> result_q == ADCPD_RES_ZEROS;
    endproperty
    a_clamp_lo: assert property (p_clamp_lo)
        else $error("low clamp wrong");
    property p_wake;
        $fell(cs_n) && powerdown_pin_n && power_q.ref_on && !power_q.ready
            |-> ##[1:5] power_q.ready;
    endproperty
    a_wake: assert property (p_wake)
        else $error("slow wake from auto power-down");
endmodule : adcpd_monitor
////////////////////////////////////////////////////////////////////////////
bind adcpd_top adcpd_monitor u_mon (.sys_clk, .resetn, .cs_n,
    .powerdown_pin_n, .above_ref_high, .below_ref_low, .power_q,
    .config_register, .result_q, .result_valid_q, .conv_busy_q);

// >>> testbench/adcpd_host_model.sv
// host serial port model: framed 16-bit words, sclk still between frames
`timescale 1ns/1ps
module adcpd_host_model (
    // serial link
    output logic sclk,
    output logic sdi,
    output logic frame_sync_in,
    output logic cs_n
);
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        frame_sync_in = 1'b0;
        cs_n = 1'b1;
    end
    // deselected clocks, only to clear the link-side reset chain
    task automatic tick(input int n);
        repeat (n) begin
            #7.5 sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
    endtask : tick
    // frame sync alone, one link clock long, as a wake source
    task automatic sync_pulse;
        frame_sync_in = 1'b1;
        #15 frame_sync_in = 1'b0;
    endtask : sync_pulse
    task automatic send_word(input logic [15:0] w);
        cs_n = 1'b0;
        #20;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i]; // msb first
            #7.5 sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
        #20 cs_n = 1'b1;
        sdi = ~sdi;
    endtask : send_word
endmodule : adcpd_host_model

// >>> testbench/test_adcpd_top.sv
// testbench: power-down controller scenarios against a host model
`timescale 1ns/1ps
module test_adcpd_top;
    import adcpd_pkg::*;
    logic sys_clk, resetn, sclk, sdi, frame_sync_in, cs_n;
    logic conversion_start_in, powerdown_pin_n, internal_ref_sel;
    logic conv_request, above_ref_high, below_ref_low, result_valid_q;
    logic conv_busy_q;
    logic [ADCPD_RES_W-1:0] raw_code, result_q;
    logic [ADCPD_CFG_W-1:0] config_register;
    adcpd_power_t power_q;
    int error_cnt = 0;
    int check_count = 0;
    // short warm-up so the run stays brief
    adcpd_top #(.WARMUP_CYC(10)) dut (.sys_clk, .resetn, .sclk, .sdi,
        .frame_sync_in, .cs_n, .conversion_start_in, .powerdown_pin_n,
        .internal_ref_sel, .conv_request, .above_ref_high, .below_ref_low,
        .raw_code, .power_q, .config_register, .result_q, .result_valid_q,
        .conv_busy_q);
    adcpd_host_model host (.sclk, .sdi, .frame_sync_in, .cs_n);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic pulse_start;
        @(negedge sys_clk) conversion_start_in = 1'b0;
        repeat (2) @(negedge sys_clk);
        conversion_start_in = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask : pulse_start
    task automatic t_conv(input logic hi, input logic lo,
                          input logic [ADCPD_RES_W-1:0] exp);
        int n = 0;
        above_ref_high = hi;
        below_ref_low = lo;
        pulse_start();
        chk("ready", 1, power_q.ready);
        conv_request = 1'b1;
        while (conv_busy_q !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        conv_request = 1'b0;
        while (result_valid_q !== 1'b1 && n < 50) begin
            @(posedge sys_clk) #1;
            n++;
        end
        chk("result", exp, result_q);
        repeat (3) @(negedge sys_clk);
        chk("ready", 0, power_q.ready);
        chk("ref_on", 1, power_q.ref_on);
    endtask : t_conv
    task automatic t_sw_pd;
        host.send_word(16'ha5c3);
        repeat (10) @(negedge sys_clk);
        chk("cfg", 12'h5c3, config_register);
        chk("busy", 0, conv_busy_q);
        internal_ref_sel = 1'b1;
        host.send_word(ADCPD_SW_PD_WORD);
        repeat (10) @(negedge sys_clk);
        chk("ref_on", 0, power_q.ref_on);
        chk("cfg", 12'h5c3, config_register);
        pulse_start();
        chk("ready", 0, power_q.ready);
        repeat (30) @(negedge sys_clk);
        chk("ready", 1, power_q.ready);
    endtask : t_sw_pd
    task automatic t_hw_pd;
        powerdown_pin_n = 1'b0;
        @(posedge sys_clk) #1;
        chk("ref_on", 0, power_q.ref_on);
        pulse_start();
        chk("ready", 0, power_q.ready);
        chk("cfg", 12'h5c3, config_register);
        powerdown_pin_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("ready", 0, power_q.ready);
        repeat (26) @(negedge sys_clk);
        pulse_start();
        chk("ready", 1, power_q.ready);
        internal_ref_sel = 1'b0;
        host.send_word(ADCPD_SW_PD_WORD);
        repeat (10) @(negedge sys_clk);
        chk("ready", 0, power_q.ready);
        host.sync_pulse();
        repeat (6) @(negedge sys_clk);
        chk("ready", 1, power_q.ready);
    endtask : t_hw_pd
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        resetn = 1'b0;
        conversion_start_in = 1'b1;
        powerdown_pin_n = 1'b1;
        internal_ref_sel = 1'b0;
        conv_request = 1'b0;
        above_ref_high = 1'b0;
        below_ref_low = 1'b0;
        raw_code = 10'h155;
        fork
            host.tick(6);
        join_none
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        // link reset chain needs sclk edges after release
        host.tick(4);
        repeat (4) @(negedge sys_clk);
        chk("ref_on", 1, power_q.ref_on);
        t_conv(1'b1, 1'b0, ADCPD_RES_ONES);
        t_conv(1'b0, 1'b1, ADCPD_RES_ZEROS);
        t_sw_pd();
        t_hw_pd();
        wrap_up();
    end
endmodule : test_adcpd_top
